// ==== tb.sv ====
// Purpose: Self-checking bench for the interrupt and FIFO control block.
// Assumes: The bench plays the UART core; the host model the processor.
// Notes:   Half-duplex mode stays off; bit ticks drive the timeout.
`timescale 1ns/1ps

module tb;
	logic       clk = 1'b0;
	logic       rst = 1'b1;
	logic [2:0] addr;
	logic [7:0] wd, rdd, rlev, rtrg, tlev, ttrg, rdat, mst, thd;
	logic [3:0] err, cbits, tsel;
	logic       wr, rd, rch, ferr, the, tae, hd, tick, xoff, xon, rts;
	logic       cts, irq, gp2, fen, dma, rfr, slp, arts, acts, receive_holding, modem_status;
	logic       thw;
	int         mismatches = 0;
	int         num_checks = 0;

	always #25 clk = ~clk;

	uifc_host_model host (.sys_clk_i(clk), .reg_addr_o(addr),
		.reg_wdata_o(wd), .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdd));
	uifc_ctrl dut (.sys_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
		.reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdd),
		.rx_level_i(rlev), .rx_trigger_i(rtrg), .tx_level_i(tlev),
		.tx_trigger_i(ttrg), .rx_data_i(rdat), .rx_char_i(rch),
		.rx_err_i(err), .rx_fifo_err_i(ferr), .thr_empty_i(the),
		.tx_all_empty_i(tae), .half_duplex_i(hd), .bit_tick_i(tick),
		.char_bits_i(cbits), .modem_status_i(mst), .xoff_detect_i(xoff),
		.xon_detect_i(xon), .rts_pin_i(rts), .cts_pin_i(cts), .irq_o(irq),
		.general_output_two_o(gp2), .fifo_enable_o(fen),
		.trigger_select_o(tsel), .dma_mode_o(dma), .rx_fifo_reset_o(rfr),
		.sleep_enable_o(slp), .auto_rts_o(arts), .auto_cts_o(acts),
		.rhr_read_o(receive_holding), .msr_read_o(modem_status), .thr_write_o(thw),
		.thr_data_o(thd));

	// -----------------------------------------------------------------
	// Shared helpers
	// -----------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] g, e);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rr(input logic [2:0] a, input logic [7:0] e);
		logic [7:0] v;
		host.rd_reg(a, v);
		chk("register", v, e);
	endtask
	task automatic w(input logic [2:0] a, input logic [7:0] d);
		host.wr_reg(a, d);
	endtask
	// Ticks are pulses with gaps, as the baud logic gives them
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk) tick <= 1'b1;
			@(posedge clk) tick <= 1'b0;
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	task automatic t_reset;
		rr(3'h1, 8'h00);
		rr(3'h2, 8'h01);
		rr(3'h7, 8'h00);
		chk("irq", {7'h0, irq}, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_prio;
		w(3'h2, 8'h01);
		w(3'h4, 8'h08);
		w(3'h1, 8'h0f);
		@(posedge clk) {err, rlev, rch} <= {4'h1, 8'h04, 1'b1};
		@(posedge clk) rch <= 1'b0;
		rr(3'h2, 8'hc6);
		chk("irq", {7'h0, irq}, 8'h01);
		rr(3'h5, 8'h63);
		err <= 4'h0;
		rr(3'h2, 8'hc4);
		rlev <= 8'h01;
		rr(3'h2, 8'hc2);
		rr(3'h2, 8'hc0);
		rr(3'h6, 8'h01);
		mst <= 8'h00;
		rr(3'h2, 8'hc1);
		chk("irq", {7'h0, irq}, 8'h00);
		$display("test priority done");
	endtask
	task automatic t_timeout;
		tk(51);
		rr(3'h2, 8'hc1);
		tk(1);
		rr(3'h2, 8'hcc);
		rr(3'h0, 8'h5a);
		rr(3'h2, 8'hc1);
		rlev <= 8'h00;
		$display("test timeout done");
	endtask
	task automatic t_enh;
		w(3'h1, 8'hf0);
		rr(3'h1, 8'h00);
		w(3'h3, 8'hd0);
		#1 chk("auto flow", {6'h0, arts, acts}, 8'h03);
		w(3'h1, 8'he0);
		rr(3'h1, 8'he0);
		@(posedge clk) xoff <= 1'b1;
		@(posedge clk) xoff <= 1'b0;
		rr(3'h2, 8'hd0);
		rr(3'h2, 8'hd1);
		@(posedge clk) xon <= 1'b1;
		@(posedge clk) xon <= 1'b0;
		rr(3'h2, 8'hc1);
		cts <= 1'b1;
		rr(3'h2, 8'he0);
		rr(3'h6, 8'h00);
		rr(3'h2, 8'hc1);
		rts <= 1'b1;
		rr(3'h2, 8'he0);
		rr(3'h6, 8'h00);
		rr(3'h2, 8'hc1);
		$display("test enhanced done");
	endtask
	task automatic t_fifo;
		w(3'h2, 8'hfb);
		#1 chk("rx reset", {7'h0, rfr}, 8'h01);
		chk("dma", {7'h0, dma}, 8'h01);
		@(posedge clk) #1 chk("rx reset", {7'h0, rfr}, 8'h00);
		chk("trigger", {4'h0, tsel}, 8'h0f);
		w(3'h2, 8'h32);
		#1 chk("rx reset", {7'h0, rfr}, 8'h00);
		chk("trigger", {4'h0, tsel}, 8'h0f);
		chk("fifo on", {7'h0, fen}, 8'h00);
		chk("dma", {7'h0, dma}, 8'h01);
		rr(3'h2, 8'h01);
		$display("test fifo done");
	endtask
	task automatic t_poll;
		w(3'h2, 8'h01);
		w(3'h1, 8'h00);
		@(posedge clk) {err, rlev, rch, ferr} <= {4'h2, 8'h04, 2'b11};
		@(posedge clk) rch <= 1'b0;
		rr(3'h2, 8'hc1);
		rr(3'h5, 8'he5);
		w(3'h1, 8'h01);
		rr(3'h2, 8'hc4);
		chk("irq", {7'h0, irq}, 8'h01);
		w(3'h4, 8'h00);
		#1 chk("irq", {7'h0, irq}, 8'h00);
		chk("gp2", {7'h0, gp2}, 8'h00);
		// Holding write must reach the transmit side as a pulse
		w(3'h0, 8'ha5);
		#1 chk("tx strobe", {7'h0, thw}, 8'h01);
		chk("tx byte", thd, 8'ha5);
		$display("test polled done");
	endtask

	// -----------------------------------------------------------------
	// Main sequence and watchdog
	// -----------------------------------------------------------------
	initial begin
		{rlev, tlev, mst, err, rch, ferr, hd, tick, xoff, xon} = '0;
		{rts, cts} = 2'b00;
		{rtrg, ttrg, rdat} = {8'h02, 8'h01, 8'h5a};
		{the, tae, cbits} = {2'b11, 4'ha};
		mst = 8'h01;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_prio;
		t_timeout;
		t_enh;
		t_fifo;
		t_poll;
		wrap_up;
	end
	// Whole run is well under two thousand cycles
	initial begin
		#200000;
		mismatches++;
		wrap_up;
	end
endmodule // tb

// ==== uifc_ctrl.sv ====
// Purpose: Interrupt enable, prioritised status and FIFO control for one
//          UART channel, behind a plain register port.
// Assumes: FIFOs, shifters, flow engines live in the UART core; levels,
//          flags and pin states arrive synchronous to sys_clk_i.
// Notes:   Read data appear in the cycle after the read strobe only.
//
// How it works
// - FIFO mode: rx interrupt follows trigger level
// - Data-ready bit set while receive FIFO nonempty
// - Line status reports error, empty, FIFO flags
// - Rx interrupt: holding full or trigger reached
// - Tx interrupt on empty, also when enabled
// - Line errors raise interrupt on arrival
// - Upper enable bits need enhanced mode
// - Auto RTS rising edge raises interrupt
// - Auto CTS rising edge raises interrupt
// - Status read shows top source, Xoff state in bit4
// - Codes: line 06, timeout 0c, rx 04
// - Codes: tx 02, modem 00, xoff 10, flow 20
// - Timeout after four chars plus twelve bits
// - Tx interrupt cleared by status read, write
// - Line clears on read; rx by level
// - Modem status read clears modem, flow
// - Xoff cleared by status read; bit4 until Xon
// - Status bit0 low while any enabled source pending
// - Status bits 7:6 mirror FIFO enable
// - FIFO control needs enable bit written high
// - Rx FIFO reset pulse, self clearing
// - Enable bits mask the four basic sources
// - Modem control bit gates interrupt output

`timescale 1ns/1ps

module uifc_ctrl #(
	parameter int LEVEL_W = 8              // FIFO level counter width
) (
	input  wire logic               sys_clk_i,        // Core clock
	input  wire logic               sys_rst_i,        // Sync reset, high
	input  wire logic [2:0]         reg_addr_i,       // Register offset
	input  wire logic [7:0]         reg_wdata_i,      // Write data
	input  wire logic               reg_wr_i,         // Write strobe
	input  wire logic               reg_rd_i,         // Read strobe
	output logic      [7:0]         reg_rdata_o,      // Read data, +1 cycle
	input  wire logic [LEVEL_W-1:0] rx_level_i,       // Rx FIFO fill
	input  wire logic [LEVEL_W-1:0] rx_trigger_i,     // Rx trigger level
	input  wire logic [LEVEL_W-1:0] tx_level_i,       // Tx FIFO fill
	input  wire logic [LEVEL_W-1:0] tx_trigger_i,     // Tx trigger level
	input  wire logic [7:0]         rx_data_i,        // Head receive byte
	input  wire logic               rx_char_i,        // Char into Rx FIFO
	input  wire logic [3:0]         rx_err_i,         // Overrun..break
	input  wire logic               rx_fifo_err_i,    // Error in FIFO
	input  wire logic               thr_empty_i,      // Holding empty
	input  wire logic               tx_all_empty_i,   // FIFO+shifter empty
	input  wire logic               half_duplex_i,    // Auto direction
	input  wire logic               bit_tick_i,       // One per bit time
	input  wire logic [3:0]         char_bits_i,      // Bits per char
	input  wire logic [7:0]         modem_status_i,   // Modem status
	input  wire logic               xoff_detect_i,    // Xoff/special seen
	input  wire logic               xon_detect_i,     // Xon seen
	input  wire logic               rts_pin_i,        // RTS output level
	input  wire logic               cts_pin_i,        // CTS input level
	output logic                    irq_o,            // Interrupt out
	output logic                    general_output_two_o, // Spare output
	output logic                    fifo_enable_o,    // FIFOs enabled
	output logic      [3:0]         trigger_select_o, // Trigger fields
	output logic                    dma_mode_o,       // DMA mode
	output logic                    rx_fifo_reset_o,  // Rx FIFO reset
	output logic                    sleep_enable_o,   // Sleep request
	output logic                    auto_rts_o,       // Auto RTS enable
	output logic                    auto_cts_o,       // Auto CTS enable
	output logic                    rhr_read_o,       // Head byte taken
	output logic                    msr_read_o,       // Deltas to clear
	output logic                    thr_write_o,      // Tx byte strobe
	output logic      [7:0]         thr_data_o        // Tx byte
);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------

	// Fixed priority: bit 0 of src is the highest level
	function automatic logic [5:0] top_code(input logic [6:0] src);
		logic [5:0] c;
		c = uifc_pkg::CODE_NONE;
		if (src[0]) begin
			c = uifc_pkg::CODE_LINE;
		end else if (src[1]) begin
			c = uifc_pkg::CODE_TIMEOUT;
		end else if (src[2]) begin
			c = uifc_pkg::CODE_RX_DATA;
		end else if (src[3]) begin
			c = uifc_pkg::CODE_TX_READY;
		end else if (src[4]) begin
			c = uifc_pkg::CODE_MODEM;
		end else if (src[5]) begin
			c = uifc_pkg::CODE_XOFF;
		end else if (src[6]) begin
			c = uifc_pkg::CODE_FLOW;
		end
		return c;
	endfunction

	// Access decode helper; neither strobe decode calls it
	function automatic logic hit(input logic stb, input logic [2:0] a,
		input logic [2:0] ofs);
		return stb && (a == ofs);
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	uifc_pkg::uifc_state_type st;
	uifc_pkg::uifc_state_type next_st;

	logic       enh;
	logic [6:0] src;
	logic [5:0] code;
	logic [7:0] status_byte;
	logic [7:0] line_byte;
	logic       rx_nonempty;
	logic       rx_avail;
	logic       tx_cond;
	logic [7:0] tmo_limit;

	// Source levels, masked by enables before priority
	always_comb begin
		enh         = st.enhanced_feature_control[uifc_pkg::EF_ENHANCE];
		rx_nonempty = (rx_level_i != '0);
		// Holding register in non-FIFO mode, trigger in FIFO mode
		rx_avail = st.fifo_en ? (rx_level_i >= rx_trigger_i)
			: rx_nonempty;
		// Empty condition for the transmit interrupt
		tx_cond = st.fifo_en ? ((tx_level_i < tx_trigger_i)
			|| (tx_level_i == '0)) : thr_empty_i;
		if (half_duplex_i) begin
			tx_cond = tx_all_empty_i;
		end
		src[0] = st.line_pend && st.interrupt_enable[uifc_pkg::EN_LINE];
		src[1] = st.tmo_pend && st.interrupt_enable[uifc_pkg::EN_RX];
		src[2] = rx_avail && st.interrupt_enable[uifc_pkg::EN_RX];
		src[3] = st.tx_pend && st.interrupt_enable[uifc_pkg::EN_TX];
		src[4] = (|modem_status_i[3:0])
			&& st.interrupt_enable[uifc_pkg::EN_MODEM];
		src[5] = st.xoff_pend && enh
			&& st.interrupt_enable[uifc_pkg::EN_XOFF];
		src[6] = st.flow_pend && enh;
		code   = top_code(src);
	end

	// Readable status words
	always_comb begin
		status_byte      = {st.fifo_en, st.fifo_en, code};
		// Bit 4 holds after the Xoff until an Xon arrives
		status_byte[4]   = code[4] || (enh && st.xoff_stat);
		if (!enh) begin
			status_byte[5:4] = 2'b00;
		end
		line_byte = {rx_fifo_err_i, tx_all_empty_i, thr_empty_i,
			rx_err_i, rx_nonempty};
		// Bit count is four characters plus twelve bits
		tmo_limit = 8'(uifc_pkg::TMO_CHARS) * {4'h0, char_bits_i}
			+ 8'(uifc_pkg::TMO_EXTRA_BITS);
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		next_st          = st;
		next_st.rdata    = '0;
		next_st.rx_reset = 1'b0;
		next_st.rhr_rd   = 1'b0;
		next_st.msr_rd   = 1'b0;
		next_st.thr_wr   = 1'b0;
		next_st.tx_cond  = tx_cond;
		next_st.rts_q    = rts_pin_i;
		next_st.cts_q    = cts_pin_i;

		// Reads: data for the next cycle, plus clearing side effects
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				uifc_pkg::OFS_HOLDING: begin
					next_st.rdata    = rx_data_i;
					next_st.rhr_rd   = 1'b1;
					next_st.tmo_pend = 1'b0;
				end
				uifc_pkg::OFS_ENABLE:     next_st.rdata = st.interrupt_enable;
				uifc_pkg::OFS_STATUS: begin
					next_st.rdata = status_byte;
					// Only a reported Tx or Xoff source is acknowledged
					if (code == uifc_pkg::CODE_TX_READY) begin
						next_st.tx_pend = 1'b0;
					end
					if (code == uifc_pkg::CODE_XOFF) begin
						next_st.xoff_pend = 1'b0;
					end
				end
				uifc_pkg::OFS_ENHANCED:   next_st.rdata = st.enhanced_feature_control;
				uifc_pkg::OFS_MODEM_CTRL: next_st.rdata = st.modem_control;
				uifc_pkg::OFS_LINE: begin
					next_st.rdata     = line_byte;
					// Flags stay in the core until bytes leave
					next_st.line_pend = 1'b0;
				end
				uifc_pkg::OFS_MODEM: begin
					next_st.rdata     = modem_status_i;
					next_st.msr_rd    = 1'b1;
					next_st.flow_pend = 1'b0;
				end
				default: next_st.rdata = '0;                // Unmapped
			endcase
		end

		// Writes
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				uifc_pkg::OFS_HOLDING: begin
					next_st.thr_wr   = 1'b1;
					next_st.thr_data = reg_wdata_i;
					next_st.tx_pend  = 1'b0;
				end
				uifc_pkg::OFS_ENABLE: begin
					next_st.interrupt_enable[3:0] = reg_wdata_i[3:0];
					if (enh) begin
						next_st.interrupt_enable[7:4] = reg_wdata_i[7:4];
					end
					// Enabling onto an already empty holding register
					if (reg_wdata_i[uifc_pkg::EN_TX]
						&& !st.interrupt_enable[uifc_pkg::EN_TX] && tx_cond) begin
						next_st.tx_pend = 1'b1;
					end
				end
				uifc_pkg::OFS_STATUS: begin
					next_st.fifo_en = reg_wdata_i[uifc_pkg::FC_ENABLE];
					// Other fields only land with the enable bit high
					if (reg_wdata_i[uifc_pkg::FC_ENABLE]) begin
						next_st.rx_reset =
							reg_wdata_i[uifc_pkg::FC_RX_RESET];
						next_st.dma = reg_wdata_i[uifc_pkg::FC_DMA];
						next_st.trig_sel[3:2] = reg_wdata_i[7:6];
						if (enh) begin
							next_st.trig_sel[1:0] =
								reg_wdata_i[5:4];
						end
					end
				end
				uifc_pkg::OFS_ENHANCED:   next_st.enhanced_feature_control = reg_wdata_i;
				uifc_pkg::OFS_MODEM_CTRL: begin
					next_st.modem_control[4:0] = reg_wdata_i[4:0];
					if (enh) begin
						next_st.modem_control[7:5] = reg_wdata_i[7:5];
					end
				end
				default: begin
					// Read-only or unmapped: write is dropped
				end
			endcase
		end

		// Event sets come last so a same-cycle clear loses
		if (rx_char_i && (|rx_err_i)) begin
			next_st.line_pend = 1'b1;
		end
		if (tx_cond && !st.tx_cond) begin
			next_st.tx_pend = 1'b1;
		end
		if (xoff_detect_i) begin
			next_st.xoff_pend = 1'b1;
			next_st.xoff_stat = 1'b1;
		end else if (xon_detect_i) begin
			next_st.xoff_stat = 1'b0;
		end
		if (rts_pin_i && !st.rts_q && st.enhanced_feature_control[uifc_pkg::EF_AUTO_RTS]
			&& st.interrupt_enable[uifc_pkg::EN_RTS]) begin
			next_st.flow_pend = 1'b1;
		end
		if (cts_pin_i && !st.cts_q && st.enhanced_feature_control[uifc_pkg::EF_AUTO_CTS]
			&& st.interrupt_enable[uifc_pkg::EN_CTS]) begin
			next_st.flow_pend = 1'b1;
		end

		// Receive timeout: restart on arrival or read, idle when empty
		if (rx_char_i || next_st.rhr_rd || !rx_nonempty
			|| !st.fifo_en || next_st.rx_reset) begin
			next_st.tmo_cnt = '0;
		end else if (bit_tick_i && !st.tmo_pend) begin
			if (st.tmo_cnt + 8'h01 >= tmo_limit) begin
				next_st.tmo_pend = 1'b1;
				next_st.tmo_cnt  = '0;
			end else begin
				next_st.tmo_cnt = st.tmo_cnt + 8'h01;
			end
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			st          <= '0;
			st.interrupt_enable      <= uifc_pkg::RESET_BYTE;
			st.enhanced_feature_control      <= uifc_pkg::RESET_BYTE;
			st.modem_control      <= uifc_pkg::RESET_BYTE;
		end else begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Interrupt pin gated by the modem control output bit
	assign irq_o = (code != uifc_pkg::CODE_NONE)
		&& st.modem_control[uifc_pkg::MC_OUT_TWO];
	assign general_output_two_o = st.modem_control[uifc_pkg::MC_OUT_TWO];
	assign reg_rdata_o          = st.rdata;
	assign fifo_enable_o        = st.fifo_en;
	assign trigger_select_o     = st.trig_sel;
	assign dma_mode_o           = st.dma;
	assign rx_fifo_reset_o      = st.rx_reset;
	assign sleep_enable_o       = st.interrupt_enable[4] && enh;
	assign auto_rts_o           = st.enhanced_feature_control[uifc_pkg::EF_AUTO_RTS];
	assign auto_cts_o           = st.enhanced_feature_control[uifc_pkg::EF_AUTO_CTS];
	assign rhr_read_o           = st.rhr_rd;
	assign msr_read_o           = st.msr_rd;
	assign thr_write_o          = st.thr_wr;
	assign thr_data_o           = st.thr_data;

endmodule // uifc_ctrl

// ==== uifc_ctrl_assertions.sv ====
// Purpose: Port-level checks of the interrupt and FIFO control block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to every instance of the control block.
`timescale 1ns/1ps

module uifc_ctrl_chk (
	input wire logic       sys_clk_i,            // Clock
	input wire logic       sys_rst_i,            // Reset
	input wire logic [2:0] reg_addr_i,           // Offset
	input wire logic [7:0] reg_wdata_i,          // Write data
	input wire logic       reg_wr_i,             // Write strobe
	input wire logic       reg_rd_i,             // Read strobe
	input wire logic [7:0] reg_rdata_o,          // Read data
	input wire logic       irq_o,                // Interrupt
	input wire logic       general_output_two_o, // Irq gate
	input wire logic       fifo_enable_o,        // FIFO on
	input wire logic       rx_fifo_reset_o,      // Rx reset
	input wire logic       sleep_enable_o,       // Sleep
	input wire logic       rhr_read_o,           // Head taken
	input wire logic       msr_read_o,           // Modem read
	input wire logic       thr_write_o,          // Tx strobe
	input wire logic [7:0] thr_data_o            // Tx byte
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	// -----------------------------------------------------------------
	// Register port
	// -----------------------------------------------------------------
	property p_rd_idle;
		!$past(reg_rd_i) |-> reg_rdata_o == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read slot");
	property p_fifo_bits;
		reg_rd_i && reg_addr_i == 3'h2
			|=> reg_rdata_o[7:6] == {2{fifo_enable_o}};
	endproperty
	a_fifo_bits: assert property (p_fifo_bits)
		else $error("status top bits differ from fifo enable");
	property p_pend_bit;
		reg_rd_i && reg_addr_i == 3'h2 && general_output_two_o
			|=> reg_rdata_o[0] == !$past(irq_o);
	endproperty
	a_pend_bit: assert property (p_pend_bit)
		else $error("status bit0 disagrees with irq");
	property p_irq_gate;
		!general_output_two_o |-> !irq_o;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("irq driven while gated off");

	// Reset pulse may stretch only under a second back-to-back write
	property p_fc_reset;
		reg_wr_i && reg_addr_i == 3'h2
			|=> rx_fifo_reset_o == (($past(reg_wdata_i) & 8'h03) == 8'h03)
			##1 (!rx_fifo_reset_o || $past(reg_wr_i));
	endproperty
	a_fc_reset: assert property (p_fc_reset)
		else $error("rx fifo reset pulse wrong");
	property p_fc_en;
		reg_wr_i && reg_addr_i == 3'h2
			|=> fifo_enable_o == |($past(reg_wdata_i) & 8'h01);
	endproperty
	a_fc_en: assert property (p_fc_en)
		else $error("fifo enable not taken from write");
	property p_thr;
		reg_wr_i && reg_addr_i == 3'h0
			|=> thr_write_o && thr_data_o == $past(reg_wdata_i);
	endproperty
	a_thr: assert property (p_thr)
		else $error("holding write not passed on");
	property p_rhr;
		rhr_read_o == ($past(reg_rd_i) && $past(reg_addr_i) == 3'h0);
	endproperty
	a_rhr: assert property (p_rhr)
		else $error("holding read pulse wrong");
	property p_msr;
		reg_rd_i && reg_addr_i == 3'h6 |=> msr_read_o;
	endproperty
	a_msr: assert property (p_msr)
		else $error("modem read pulse missing");
	property p_sleep;
		$rose(sleep_enable_o) |-> $past(reg_wr_i);
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep enable rose without write");

	// Main scenarios reached
	c_irq: cover property ($rose(irq_o));
	c_rfr: cover property (rx_fifo_reset_o);
	c_tmo: cover property (reg_rd_i && reg_addr_i == 3'h2
		##1 reg_rdata_o[5:0] == 6'h0c);
endmodule // uifc_ctrl_chk

bind uifc_ctrl uifc_ctrl_chk u_chk (.*);

// ==== uifc_host_model.sv ====
// Purpose: Host processor model on the plain register port.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes:   Every signal changes by NBA right after a rising edge.
`timescale 1ns/1ps

module uifc_host_model (
	input  wire logic       sys_clk_i,   // Core clock
	output logic      [2:0] reg_addr_o,  // Register offset
	output logic      [7:0] reg_wdata_o, // Write data
	output logic            reg_wr_o,    // Write strobe
	output logic            reg_rd_o,    // Read strobe
	input  wire logic [7:0] reg_rdata_i  // Read data
);
	initial begin
		reg_addr_o  = 3'h0;
		reg_wdata_o = 8'h00;
		reg_wr_o    = 1'b0;
		reg_rd_o    = 1'b0;
	end

	// One-cycle write; caller sets the enable bits first
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_o  <= a;
		reg_wdata_o <= d;
		reg_wr_o    <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_o    <= 1'b0;
	endtask

	// One-cycle read; data taken once the answering edge has landed
	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		reg_addr_o <= a;
		reg_rd_o   <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_o   <= 1'b0;
		#1 d = reg_rdata_i;
	endtask
endmodule // uifc_host_model

// ==== uifc_pkg.sv ====
// Purpose: Shared constants and state carrier for the UART interrupt and
//          FIFO control block.
// Assumes: 3-bit register port, 8-bit data.
// Notes:   Offsets follow the usual UART register layout where needed.

package uifc_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam int          ADDR_W         = 3;
	localparam logic [2:0]  OFS_HOLDING    = 3'h0; // Rx read / Tx write
	localparam logic [2:0]  OFS_ENABLE     = 3'h1;
	localparam logic [2:0]  OFS_STATUS     = 3'h2; // Read status, write FIFO
	localparam logic [2:0]  OFS_ENHANCED   = 3'h3;
	localparam logic [2:0]  OFS_MODEM_CTRL = 3'h4;
	localparam logic [2:0]  OFS_LINE       = 3'h5;
	localparam logic [2:0]  OFS_MODEM      = 3'h6;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int          FC_ENABLE      = 0;
	localparam int          FC_RX_RESET    = 1;
	localparam int          FC_DMA         = 3;
	localparam int          EN_RX          = 0;
	localparam int          EN_TX          = 1;
	localparam int          EN_LINE        = 2;
	localparam int          EN_MODEM       = 3;
	localparam int          EN_XOFF        = 5;
	localparam int          EN_RTS         = 6;
	localparam int          EN_CTS         = 7;
	localparam int          EF_ENHANCE     = 4;
	localparam int          EF_AUTO_RTS    = 6;
	localparam int          EF_AUTO_CTS    = 7;
	localparam int          MC_OUT_TWO     = 3;
	localparam logic [7:0]  RESET_BYTE     = 8'h00;

	// ------------------------------------------------------------------
	// Interrupt status codes, bits 5..0
	// ------------------------------------------------------------------
	localparam logic [5:0]  CODE_LINE      = 6'h06;
	localparam logic [5:0]  CODE_TIMEOUT   = 6'h0c;
	localparam logic [5:0]  CODE_RX_DATA   = 6'h04;
	localparam logic [5:0]  CODE_TX_READY  = 6'h02;
	localparam logic [5:0]  CODE_MODEM     = 6'h00;
	localparam logic [5:0]  CODE_XOFF      = 6'h10;
	localparam logic [5:0]  CODE_FLOW      = 6'h20;
	localparam logic [5:0]  CODE_NONE      = 6'h01;

	// ------------------------------------------------------------------
	// Receive timeout: character times plus extra bit times
	// ------------------------------------------------------------------
	localparam int          TMO_CHARS      = 4;
	localparam int          TMO_EXTRA_BITS = 12;

	// Whole block state, registered as one word
	typedef struct packed {
		logic [7:0] interrupt_enable;
		logic       fifo_en;
		logic [3:0] trig_sel;
		logic       dma;
		logic [7:0] enhanced_feature_control;
		logic [7:0] modem_control;
		logic       rx_reset;
		logic       line_pend;
		logic       tx_pend;
		logic       tx_cond;
		logic       tmo_pend;
		logic [7:0] tmo_cnt;
		logic       xoff_pend;
		logic       xoff_stat;
		logic       flow_pend;
		logic       rts_q;
		logic       cts_q;
		logic [7:0] rdata;
		logic       rhr_rd;
		logic       msr_rd;
		logic       thr_wr;
		logic [7:0] thr_data;
	} uifc_state_type;

endpackage
